// ===== flash_guard_pkg.sv
// Shared constants, types and decode functions for flash sector protection.
package flash_guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the byte-wide register port.
  localparam logic [7:0] GUARD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h05;
  localparam logic [7:0] VADDR_HI_OFS = 8'h06;
  localparam logic [7:0] VADDR_LO_OFS = 8'h07;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the guard register and the status register.
  localparam int POL_BIT = 7;
  localparam int SPARE_BIT = 6;
  localparam int HOFF_BIT = 5;
  localparam int HSZ_LO = 3;
  localparam int LOFF_BIT = 2;
  localparam int LSZ_LO = 0;
  localparam int VIOL_BIT = 5;
  localparam int REFUSED_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and nonvolatile source of the guard byte.
  localparam logic [7:0] GUARD_RST = 8'hff;
  localparam logic [15:0] VADDR_RST = 16'h0000;
  localparam logic [15:0] NV_GUARD_ADDR = 16'hff0d;

  ////////////////////////////////////////////////////////////////////////////
  // Range bounds.
  localparam logic [15:0] LOW_BASE = 16'h4000;
  localparam logic [15:0] HIGH_END = 16'hffff;
  localparam int PROBES = 9;
  // One address inside each region that the two ranges can split the map into, except 16'h6000 to 16'hbfff, which decodes like 16'h0000.
  localparam logic [15:0] PROBE_ADDR [PROBES] = '{16'h0000, 16'h4000,
    16'h4400, 16'h4800, 16'h5000, 16'hc000, 16'he000, 16'hf000, 16'hf800};

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    CMD_PROGRAM = 2'h0,
    CMD_SECTOR_ERASE = 2'h1,
    CMD_MASS_ERASE = 2'h2
  } cmd_kind_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h1,
    ST_RUN = 2'h2
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions.
  function automatic logic [15:0] high_start(input logic [1:0] sz);
    case (sz)
      2'h0: high_start = 16'hf800;
      2'h1: high_start = 16'hf000;
      2'h2: high_start = 16'he000;
      default: high_start = 16'hc000;
    endcase
  endfunction

  function automatic logic [15:0] low_end(input logic [1:0] sz);
    case (sz)
      2'h0: low_end = 16'h43ff;
      2'h1: low_end = 16'h47ff;
      2'h2: low_end = 16'h4fff;
      default: low_end = 16'h5fff;
    endcase
  endfunction

  // True when the address is guarded under the given guard byte.
  function automatic logic is_guarded(input logic [7:0] cfg,
                                      input logic [15:0] addr);
    logic hi_sel;
    logic lo_sel;
    hi_sel = !cfg[HOFF_BIT] && (addr >= high_start(cfg[HSZ_LO +: 2]));
    lo_sel = !cfg[LOFF_BIT] && (addr >= LOW_BASE) &&
             (addr <= low_end(cfg[LSZ_LO +: 2]));
    is_guarded = cfg[POL_BIT] ? (hi_sel || lo_sel) : !(hi_sel || lo_sel);
  endfunction

endpackage

// ===== guard_address_check.sv
// Combinational protection decision for one command target address.
module guard_address_check (
  // Active guard byte.
  input wire logic [7:0] cfg,
  // Command target.
  input wire logic [15:0] addr,
  // Decision.
  output logic addr_guarded,
  output logic mass_allowed
);

  ////////////////////////////////////////////////////////////////////////////
  // The decision is settled before launch, so no cycle is lost.
  always_comb begin
    addr_guarded = flash_guard_pkg::is_guarded(cfg, addr);
    mass_allowed = cfg[flash_guard_pkg::POL_BIT] &&
                   cfg[flash_guard_pkg::HOFF_BIT] &&
                   cfg[flash_guard_pkg::LOFF_BIT];
  end

endmodule

// ===== guard_write_filter.sv
// Filters a software write to the guard byte so protection only grows.
module guard_write_filter (
  // Current and proposed guard bytes.
  input wire logic [7:0] cur_cfg,
  input wire logic [7:0] wr_cfg,
  // Filtered result.
  output logic [7:0] merged_cfg,
  output logic accept
);

  logic [flash_guard_pkg::PROBES-1:0] keeps;

  ////////////////////////////////////////////////////////////////////////////
  // Field-level write restrictions.
  always_comb begin
    merged_cfg = wr_cfg;
    merged_cfg[flash_guard_pkg::POL_BIT] =
      cur_cfg[flash_guard_pkg::POL_BIT] &
      wr_cfg[flash_guard_pkg::POL_BIT];
    if (!cur_cfg[flash_guard_pkg::LOFF_BIT]) begin
      merged_cfg[flash_guard_pkg::LSZ_LO +: 2] =
        cur_cfg[flash_guard_pkg::LSZ_LO +: 2];
    end
    if (!cur_cfg[flash_guard_pkg::HOFF_BIT]) begin
      merged_cfg[flash_guard_pkg::HSZ_LO +: 2] =
        cur_cfg[flash_guard_pkg::HSZ_LO +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every region guarded now must stay guarded; one probe per region is
  // enough because 16'h6000 to 16'hbfff, the one span without a probe, decodes like 16'h0000.
  genvar gi;
  generate
    for (gi = 0; gi < flash_guard_pkg::PROBES; gi++) begin : g_probe
      assign keeps[gi] =
        !flash_guard_pkg::is_guarded(cur_cfg,
                                     flash_guard_pkg::PROBE_ADDR[gi]) ||
        flash_guard_pkg::is_guarded(merged_cfg,
                                    flash_guard_pkg::PROBE_ADDR[gi]);
    end
  endgenerate

  assign accept = &keeps;

endmodule

// ===== flash_sector_protection.sv
// Flash sector protection: guard register, reset-time load, command check.
module flash_sector_protection (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Nonvolatile guard byte fetch during the reset sequence.
  output logic nv_load_req,
  output logic [15:0] nv_load_addr,
  input wire logic nv_load_valid,
  input wire logic [7:0] nv_load_data,
  // Command requests from the flash command controller.
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_addr,
  output logic cmd_ready,
  output logic cmd_launch,
  output logic cmd_blocked,
  // Protection state for the array.
  output logic [7:0] guard_cfg,
  output logic guard_violation_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  flash_guard_pkg::state_t state_ff;
  flash_guard_pkg::state_t nxt_state;
  logic [7:0] guard_ff;
  logic [7:0] nxt_guard;
  logic viol_ff;
  logic nxt_viol;
  logic refused_ff;
  logic nxt_refused;
  logic [15:0] vaddr_ff;
  logic [7:0] rdata_ff;
  logic nv_req_ff;
  logic [15:0] nv_addr_ff;
  logic ready_ff;
  logic launch_ff;
  logic blocked_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded strobes and helper terms.
  logic running;
  logic wr_guard;
  logic wr_status;
  logic cmd_take;
  logic cmd_bad;
  logic cmd_known;
  logic addr_guarded;
  logic mass_allowed;
  logic [7:0] merged_cfg;
  logic write_ok;

  assign running = (state_ff == flash_guard_pkg::ST_RUN);
  assign wr_guard = reg_wr && (reg_addr == flash_guard_pkg::GUARD_OFS);
  assign wr_status = reg_wr && (reg_addr == flash_guard_pkg::STATUS_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Address check and write filter.
  guard_address_check u_check (
    .cfg(guard_ff),
    .addr(cmd_addr),
    .addr_guarded(addr_guarded),
    .mass_allowed(mass_allowed)
  );

  guard_write_filter u_filter (
    .cur_cfg(guard_ff),
    .wr_cfg(reg_wdata),
    .merged_cfg(merged_cfg),
    .accept(write_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequence: fetch the guard byte before any command may run.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      flash_guard_pkg::ST_LOAD: begin
        if (nv_load_valid) begin
          nxt_state = flash_guard_pkg::ST_RUN;
        end
      end
      flash_guard_pkg::ST_RUN: begin
        nxt_state = flash_guard_pkg::ST_RUN;
      end
      default: begin
        nxt_state = flash_guard_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= flash_guard_pkg::ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nv_req_ff <= 1'b0;
      nv_addr_ff <= flash_guard_pkg::NV_GUARD_ADDR;
    end else begin
      // The request drops in the cycle after the byte arrives.
      nv_req_ff <= (nxt_state == flash_guard_pkg::ST_LOAD);
      nv_addr_ff <= flash_guard_pkg::NV_GUARD_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guard register. The range meaning lives in the shared decode function.
  always_comb begin
    nxt_guard = guard_ff;
    nxt_refused = refused_ff;
    if (state_ff == flash_guard_pkg::ST_LOAD) begin
      if (nv_load_valid) begin
        nxt_guard = nv_load_data;
      end
    end else begin
      if (wr_guard) begin
        if (write_ok) begin
          nxt_guard = merged_cfg;
        end else begin
          // Dropped whole, not partly applied.
          nxt_refused = 1'b1;
        end
      end
    end
    if (wr_status && reg_wdata[flash_guard_pkg::REFUSED_BIT]) begin
      if (!(wr_guard && !write_ok && running)) begin
        nxt_refused = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      guard_ff <= flash_guard_pkg::GUARD_RST;
    end else begin
      guard_ff <= nxt_guard;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= nxt_refused;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command check. The violation flag blocks every launch, so a second
  // bad command cannot overwrite the captured address.
  always_comb begin
    cmd_known = (cmd_kind == flash_guard_pkg::CMD_PROGRAM) ||
                (cmd_kind == flash_guard_pkg::CMD_SECTOR_ERASE) ||
                (cmd_kind == flash_guard_pkg::CMD_MASS_ERASE);
    cmd_take = cmd_valid && running && !viol_ff && cmd_known;
    if (cmd_kind == flash_guard_pkg::CMD_MASS_ERASE) begin
      cmd_bad = !mass_allowed;
    end else begin
      cmd_bad = addr_guarded;
    end
  end

  always_comb begin
    nxt_viol = viol_ff;
    if (wr_status && reg_wdata[flash_guard_pkg::VIOL_BIT]) begin
      nxt_viol = 1'b0;
    end
    // A new violation wins over a clear in the same cycle.
    if (cmd_take && cmd_bad) begin
      nxt_viol = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      viol_ff <= 1'b0;
    end else begin
      viol_ff <= nxt_viol;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vaddr_ff <= flash_guard_pkg::VADDR_RST;
    end else if (cmd_take && cmd_bad) begin
      vaddr_ff <= cmd_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      launch_ff <= 1'b0;
      blocked_ff <= 1'b0;
    end else begin
      // The array sees a launch only for a clean command.
      launch_ff <= cmd_take && !cmd_bad;
      blocked_ff <= cmd_take && cmd_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == flash_guard_pkg::ST_RUN) && !nxt_viol;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads: data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        flash_guard_pkg::GUARD_OFS: begin
          rdata_ff <= guard_ff;
        end
        flash_guard_pkg::STATUS_OFS: begin
          rdata_ff <= {2'h0, viol_ff, 4'h0, refused_ff};
        end
        flash_guard_pkg::VADDR_HI_OFS: begin
          rdata_ff <= vaddr_ff[15:8];
        end
        flash_guard_pkg::VADDR_LO_OFS: begin
          rdata_ff <= vaddr_ff[7:0];
        end
        default: begin
          rdata_ff <= 8'h00;
        end
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.
  assign reg_rdata = rdata_ff;
  assign nv_load_req = nv_req_ff;
  assign nv_load_addr = nv_addr_ff;
  assign cmd_ready = ready_ff;
  assign cmd_launch = launch_ff;
  assign cmd_blocked = blocked_ff;
  assign guard_cfg = guard_ff;
  assign guard_violation_flag = viol_ff;

endmodule

// ===== guard_monitor.sv
// Assertion checker watching the flash sector protection ports.
module guard_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Nonvolatile load.
  input wire logic nv_load_req,
  input wire logic [15:0] nv_load_addr,
  input wire logic nv_load_valid,
  input wire logic [7:0] nv_load_data,
  // Commands.
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_ready,
  input wire logic cmd_launch,
  input wire logic cmd_blocked,
  // Protection state.
  input wire logic [7:0] guard_cfg,
  input wire logic guard_violation_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic open_all;
  // A command counts only when the block says it is ready for one.
  assign take = cmd_valid && cmd_ready && cmd_kind != 2'h3;
  assign open_all = guard_cfg[7] && guard_cfg[5] && guard_cfg[2];
  ////////////////////////////////////////////////////////////////////////////
  a_one_answer: assert property (take |=> cmd_launch != cmd_blocked)
    else $error("accepted command got no single answer");
  a_no_spurious: assert property (!take |=> !cmd_launch && !cmd_blocked)
    else $error("answer without an accepted command");
  a_mass_guarded: assert property (take && cmd_kind == 2'h2 && !open_all
    |=> cmd_blocked && guard_violation_flag)
    else $error("mass erase passed under protection");
  a_all_open: assert property (take && open_all |=> cmd_launch)
    else $error("command blocked with protection off");
  a_all_shut: assert property (take && !guard_cfg[7] && guard_cfg[5] &&
    guard_cfg[2] |=> cmd_blocked)
    else $error("command passed with whole array guarded");
  a_blocked_flag: assert property (cmd_blocked |-> guard_violation_flag)
    else $error("blocked command left the flag clear");
  a_flag_sticky: assert property (guard_violation_flag && !(reg_wr &&
    reg_addr == flash_guard_pkg::STATUS_OFS && reg_wdata[5])
    |=> guard_violation_flag)
    else $error("violation flag dropped without a clear");
  a_flag_stalls: assert property (guard_violation_flag |-> !cmd_ready)
    else $error("ready while violation flag set");
  a_pol_clear: assert property (!guard_cfg[7] |=> !guard_cfg[7])
    else $error("polarity bit set again");
  a_low_frozen: assert property (!guard_cfg[2] |=> $stable(guard_cfg[1:0]))
    else $error("low size changed while low range on");
  a_high_frozen: assert property (!guard_cfg[5] |=> $stable(guard_cfg[4:3]))
    else $error("high size changed while high range on");
  a_read_back: assert property (reg_rd && reg_addr == flash_guard_pkg::GUARD_OFS
    |=> reg_rdata == $past(guard_cfg))
    else $error("guard read returned wrong byte");
  a_load_take: assert property (nv_load_req && nv_load_valid
    |=> guard_cfg == $past(nv_load_data) && !nv_load_req)
    else $error("nonvolatile byte not loaded");
  a_load_addr: assert property (nv_load_req
    |-> nv_load_addr == flash_guard_pkg::NV_GUARD_ADDR)
    else $error("wrong nonvolatile fetch address");
  c_load: cover property (nv_load_req && nv_load_valid);
  c_blocked: cover property (cmd_blocked);
  c_mass: cover property (take && cmd_kind == 2'h2 ##1 cmd_launch);
endmodule

// ===== nv_store_model.sv
// Nonvolatile store answering the guard byte fetch after a delay.
module nv_store_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Fetch request.
  input wire logic nv_load_req,
  input wire logic [15:0] nv_load_addr,
  // Stored byte and answer delay.
  input wire logic [7:0] nv_byte,
  input wire logic [3:0] wait_cycles,
  // Answer.
  output logic nv_load_valid,
  output logic [7:0] nv_load_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (rst || !nv_load_req || nv_load_valid) begin
      cnt_ff <= 4'h0;
      nv_load_valid <= 1'b0;
    end else if (cnt_ff == wait_cycles) begin
      nv_load_valid <= nv_load_addr == flash_guard_pkg::NV_GUARD_ADDR;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  // Outside the answer the lines carry junk so a stale byte never matches.
  assign nv_load_data = nv_load_valid ? nv_byte : ~nv_byte;
endmodule

// ===== tb_top.sv
// Self-checking testbench for flash sector protection.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, reg_wr, reg_rd, nv_load_req, nv_load_valid, cmd_valid;
  logic cmd_ready, cmd_launch, cmd_blocked, guard_violation_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nv_load_data, guard_cfg;
  logic [7:0] nv_byte;
  logic [15:0] nv_load_addr, cmd_addr;
  logic [1:0] cmd_kind;
  logic [3:0] wait_cycles;
  int errors;
  int checks;
  ////////////////////////////////////////////////////////////////////////////
  flash_sector_protection i_flash_sector_protection (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_load_req(nv_load_req),
    .nv_load_addr(nv_load_addr), .nv_load_valid(nv_load_valid),
    .nv_load_data(nv_load_data), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .cmd_launch(cmd_launch),
    .cmd_blocked(cmd_blocked), .guard_cfg(guard_cfg),
    .guard_violation_flag(guard_violation_flag));
  nv_store_model i_nv_store_model (.clk(clk), .rst(rst),
    .nv_load_req(nv_load_req), .nv_load_addr(nv_load_addr),
    .nv_byte(nv_byte), .wait_cycles(wait_cycles),
    .nv_load_valid(nv_load_valid), .nv_load_data(nv_load_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Expected answer lb is {launch, blocked}; a block is cleared unless kept.
  task automatic cmd(input logic [1:0] k, input logic [15:0] a,
                     input logic [1:0] lb, input logic keep = 1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk({cmd_launch, cmd_blocked}, lb);
    if (lb[0]) begin
      chk({guard_violation_flag, cmd_ready}, 2'h2);
      if (!keep) wr(flash_guard_pkg::STATUS_OFS, 8'h20);
    end
  endtask
  // Table entries are kind, address and expected answer in hex digits.
  task automatic run_tab(input logic [23:0] tv [6]);
    for (int i = 0; i < 6; i++) begin
      cmd(tv[i][21:20], tv[i][19:4], tv[i][1:0]);
    end
  endtask
  task automatic boot();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(flash_guard_pkg::GUARD_OFS, flash_guard_pkg::GUARD_RST);
    for (int i = 0; i < 40 && cmd_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(guard_cfg, nv_byte);
    rd(flash_guard_pkg::GUARD_OFS, nv_byte);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_open();
    cmd(2'h2, 16'h0000, 2'h2);
    cmd(2'h0, 16'hffff, 2'h2);
    cmd(2'h3, 16'h0000, 2'h0);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_ranges();
    wr(flash_guard_pkg::GUARD_OFS, 8'hd1);
    rd(flash_guard_pkg::GUARD_OFS, 8'hd1);
    run_tab('{24'h0e0001, 24'h0dfff2, 24'h047ff1, 24'h048002, 24'h03fff2,
      24'h200001});
  endtask
  task automatic t_freeze();
    wr(flash_guard_pkg::GUARD_OFS, 8'hdb);
    rd(flash_guard_pkg::GUARD_OFS, 8'hd1);
    wr(flash_guard_pkg::GUARD_OFS, 8'hd5);
    rd(flash_guard_pkg::GUARD_OFS, 8'hd1);
    rd(flash_guard_pkg::STATUS_OFS, 8'h01);
    wr(flash_guard_pkg::STATUS_OFS, 8'h01);
    rd(flash_guard_pkg::STATUS_OFS, 8'h00);
  endtask
  task automatic t_shut();
    wr(flash_guard_pkg::GUARD_OFS, 8'h7f);
    rd(flash_guard_pkg::GUARD_OFS, 8'h75);
    wr(flash_guard_pkg::GUARD_OFS, 8'hf5);
    rd(flash_guard_pkg::GUARD_OFS, 8'h75);
    cmd(2'h0, 16'h8123, 2'h1, 1'b1);
    // The blocked target is captured for software to inspect.
    rd(flash_guard_pkg::VADDR_HI_OFS, 8'h81);
    rd(flash_guard_pkg::VADDR_LO_OFS, 8'h23);
    cmd(2'h1, 16'h0000, 2'h0);
    wr(flash_guard_pkg::STATUS_OFS, 8'hdf);
    rd(flash_guard_pkg::STATUS_OFS, 8'h20);
    wr(flash_guard_pkg::STATUS_OFS, 8'h20);
    rd(flash_guard_pkg::STATUS_OFS, 8'h00);
  endtask
  task automatic t_window();
    nv_byte <= 8'h48;
    boot();
    run_tab('{24'h000001, 24'h0efff1, 24'h0f0002, 24'h143ff2, 24'h044001,
      24'h200001});
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(3000 * 100);
    errors++;
    close_out();
  end
  initial begin
    errors = 0;
    checks = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 16'h0000;
    nv_byte = 8'hff;
    wait_cycles = 4'h8;
    boot();
    t_open();
    t_ranges();
    t_freeze();
    t_shut();
    t_window();
    close_out();
  end
endmodule

bind flash_sector_protection guard_monitor i_guard_monitor (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_load_req(nv_load_req),
  .nv_load_addr(nv_load_addr), .nv_load_valid(nv_load_valid),
  .nv_load_data(nv_load_data), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
  .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .cmd_launch(cmd_launch),
  .cmd_blocked(cmd_blocked), .guard_cfg(guard_cfg),
  .guard_violation_flag(guard_violation_flag));
